// ---- logic/irq_ctrl_pkg.sv ----
// Constants, register offsets and field layout of the vectored interrupt controller.
// Behaviour
// - Each source has its own mode register with a trigger type field.
// - Internal sources are level or edge detected; polarity is not user visible.
// - External sources detect high level, low level, rising or falling edge.
// - Enable and disable command writes act on one-bits only, one access.
// - The enable mask register shows the result of all enable commands.
// - A disabled source never affects resolution, line or servicing of others.
// - Set and clear command writes set or clear latched edges, source 0 too.
// - Set and clear commands do nothing to level-sensitive sources.
// - Normal vector read clears the latched edge of the chosen source only.
// - No auto clear on normal vector read for fast-forced sources.
// - Source 0 edge is cleared by a fast vector read instead.
// - Pending register shows every source's activity, enabled or not.
// - Current number register returns the source being serviced.
// - Core line status register shows both request lines.
// - Normal line comes from sources 1 to 31, not fast-forced, eight levels.
// - Three-bit priority per source; seven highest, zero lowest.
// - Current interrupt is chosen at vector read; level becomes its priority.
// - Ties at the top priority go to the lowest source number.
// - While serving, only strictly higher priority raises the normal line.
// - A vector read pushes number and level; end of service restores them.
// - The nesting stack holds eight entries.
// - Normal vector read returns the selected source's handler vector.
// - A normal vector read deasserts the normal request line.
// - End of service pops the stack and re-raises the line if outranked.
package irq_ctrl_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets.
    // ------------------------------------------------------------------
    localparam logic [9:0] MODE_BASE = 10'h000;
    localparam logic [9:0] VECT_BASE = 10'h080;
    localparam logic [9:0] NORMAL_VECTOR_OFS = 10'h100;
    localparam logic [9:0] FAST_VECTOR_OFS = 10'h104;
    localparam logic [9:0] CURRENT_NUMBER_OFS = 10'h108;
    localparam logic [9:0] PENDING_OFS = 10'h10C;
    localparam logic [9:0] ENABLE_MASK_OFS = 10'h110;
    localparam logic [9:0] CORE_LINE_OFS = 10'h114;
    localparam logic [9:0] ENABLE_CMD_OFS = 10'h120;
    localparam logic [9:0] DISABLE_CMD_OFS = 10'h124;
    localparam logic [9:0] CLEAR_CMD_OFS = 10'h128;
    localparam logic [9:0] SET_CMD_OFS = 10'h12C;
    localparam logic [9:0] END_OF_SERVICE_OFS = 10'h130;
    localparam logic [9:0] FAST_FORCE_OFS = 10'h140;
    localparam logic [9:0] EXTERNAL_SEL_OFS = 10'h144;
    // ------------------------------------------------------------------
    // Mode register fields.
    // ------------------------------------------------------------------
    localparam int PRIO_LSB = 0;
    localparam int PRIO_MSB = 2;
    localparam int TYPE_LSB = 5;
    localparam int TYPE_MSB = 6;
    localparam logic [1:0] TYPE_LOW_LEVEL = 2'h0;
    localparam logic [1:0] TYPE_FALL_EDGE = 2'h1;
    localparam logic [1:0] TYPE_HIGH_LEVEL = 2'h2;
    localparam logic [1:0] TYPE_RISE_EDGE = 2'h3;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] VECT_RESET = 32'h0000_0000;
    localparam int STACK_DEPTH = 8;
endpackage : irq_ctrl_pkg

// ---- logic/vectored_irq_ctrl.sv ----
// Vectored priority interrupt controller with classic Wishbone slave.
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ns
module vectored_irq_ctrl #(
    parameter int NUM_SRC = 32
) (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [31:0] SRC_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [9:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic NORMAL_REQUEST_N_OUT,
    output logic FAST_REQUEST_N_OUT
);
    // Source 0 is the fast source and sources 1.. feed the resolver.
    initial begin
        if (NUM_SRC != 32) begin
            $error("NUM_SRC must be 32");
        end
    end

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    logic [31:0] mode_r [32];
    logic [31:0] vect_r [32];
    logic [31:0] enable_r;
    logic [31:0] edge_r;
    logic [31:0] src_prev_r;
    logic [31:0] force_r;
    logic [31:0] ext_sel_r;
    logic [4:0] cur_num_r;
    logic [2:0] cur_lvl_r;
    logic [3:0] sp_r;
    logic [4:0] stk_num_r [8];
    logic [2:0] stk_lvl_r [8];
    logic normal_request_n_r;
    logic ack_r;
    logic [31:0] rdata_r;

    // Bus strobes: one access per classic cycle, answered one clock later.
    logic req;
    logic wr;
    logic rd;
    logic [31:0] wmask;
    assign req = WB_CYC_IN & WB_STB_IN & ~ack_r;
    assign wr = req & WB_WE_IN;
    assign rd = req & ~WB_WE_IN;
    assign wmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
                    {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};

    logic ivr_rd;
    logic fvr_rd;
    logic eoi_wr;
    assign ivr_rd = rd & (WB_ADR_IN == irq_ctrl_pkg::NORMAL_VECTOR_OFS);
    assign fvr_rd = rd & (WB_ADR_IN == irq_ctrl_pkg::FAST_VECTOR_OFS);
    assign eoi_wr = wr & (WB_ADR_IN == irq_ctrl_pkg::END_OF_SERVICE_OFS);

    function automatic logic cmd_wr(input logic [9:0] ofs);
        cmd_wr = wr & (WB_ADR_IN == ofs);
    endfunction : cmd_wr

    // ------------------------------------------------------------------
    // Per-source input stage.
    // ------------------------------------------------------------------
    logic [31:0] is_edge;
    logic [31:0] active;
    logic [31:0] edge_hit;
    logic [31:0] pending;
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_src
            logic [1:0] ty;
            logic lvl;
            logic hi;
            assign ty = mode_r[g][irq_ctrl_pkg::TYPE_MSB:irq_ctrl_pkg::TYPE_LSB];
            // Internal sources ignore polarity; only the type's edge bit counts.
            assign hi = ext_sel_r[g] ? ty[1] : 1'b1;
            assign is_edge[g] = ty[0];
            assign lvl = hi ? SRC_IN[g] : ~SRC_IN[g];
            assign active[g] = lvl;
            assign edge_hit[g] = hi ? (SRC_IN[g] & ~src_prev_r[g])
                                    : (~SRC_IN[g] & src_prev_r[g]);
            assign pending[g] = is_edge[g] ? edge_r[g] : active[g];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Priority resolver over enabled, non-forced sources 1 to 31.
    // ------------------------------------------------------------------
    logic [31:0] cand;
    logic best_ok;
    logic [4:0] best_num;
    logic [2:0] best_lvl;
    assign cand = pending & enable_r & ~force_r & 32'hFFFF_FFFE;
    always_comb begin
        best_ok = 1'b0;
        best_num = 5'h0;
        best_lvl = 3'h0;
        // Descending scan with >= keeps the lowest number on ties.
        for (int i = 31; i >= 1; i--) begin
            if (cand[i] && (!best_ok ||
                mode_r[i][irq_ctrl_pkg::PRIO_MSB:irq_ctrl_pkg::PRIO_LSB]
                >= best_lvl)) begin
                best_ok = 1'b1;
                best_num = 5'(i);
                best_lvl =
                    mode_r[i][irq_ctrl_pkg::PRIO_MSB:irq_ctrl_pkg::PRIO_LSB];
            end
        end
    end

    // Servicing is active while the stack holds an entry.
    logic serving;
    logic normal_request_n_nxt;
    assign serving = (sp_r != 4'h0);
    assign normal_request_n_nxt = best_ok & (!serving || best_lvl > cur_lvl_r);

    // Fast line: source 0 plus any fast-forced source, each only while enabled.
    logic fiq;
    assign fiq = |(pending & enable_r & (force_r | 32'h0000_0001));

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            for (int i = 0; i < 32; i++) begin
                mode_r[i] <= irq_ctrl_pkg::MODE_RESET;
                vect_r[i] <= irq_ctrl_pkg::VECT_RESET;
            end
            force_r <= 32'h0000_0000;
            ext_sel_r <= 32'h0000_0000;
        end else if (wr) begin
            for (int i = 0; i < 32; i++) begin
                if (WB_ADR_IN == irq_ctrl_pkg::MODE_BASE + 10'(i * 4)) begin
                    mode_r[i] <= (mode_r[i] & ~wmask) | (WB_DAT_IN & wmask);
                end
                if (WB_ADR_IN == irq_ctrl_pkg::VECT_BASE + 10'(i * 4)) begin
                    vect_r[i] <= (vect_r[i] & ~wmask) | (WB_DAT_IN & wmask);
                end
            end
            if (WB_ADR_IN == irq_ctrl_pkg::FAST_FORCE_OFS) begin
                force_r <= (force_r & ~wmask) | (WB_DAT_IN & wmask);
            end
            if (WB_ADR_IN == irq_ctrl_pkg::EXTERNAL_SEL_OFS) begin
                ext_sel_r <= (ext_sel_r & ~wmask) | (WB_DAT_IN & wmask);
            end
        end
    end

    // Enable mask: one-bits of the command data act, zeros leave bits alone.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            enable_r <= 32'h0000_0000;
        end else if (cmd_wr(irq_ctrl_pkg::ENABLE_CMD_OFS)) begin
            enable_r <= enable_r | (WB_DAT_IN & wmask);
        end else if (cmd_wr(irq_ctrl_pkg::DISABLE_CMD_OFS)) begin
            enable_r <= enable_r & ~(WB_DAT_IN & wmask);
        end
    end

    // Edge latches: a detected edge wins over any clear in the same cycle.
    logic [31:0] clr_bits;
    logic [31:0] set_bits;
    always_comb begin
        clr_bits = 32'h0000_0000;
        set_bits = 32'h0000_0000;
        if (cmd_wr(irq_ctrl_pkg::CLEAR_CMD_OFS)) begin
            clr_bits = WB_DAT_IN & wmask;
        end
        if (cmd_wr(irq_ctrl_pkg::SET_CMD_OFS)) begin
            set_bits = WB_DAT_IN & wmask;
        end
        if (ivr_rd && best_ok && !force_r[best_num]) begin
            clr_bits[best_num] = 1'b1;
        end
        if (fvr_rd) begin
            clr_bits[0] = 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            edge_r <= 32'h0000_0000;
            src_prev_r <= 32'h0000_0000;
        end else begin
            src_prev_r <= SRC_IN;
            // Level sources never hold a latch, so set and clear are void.
            edge_r <= is_edge & ((edge_r & ~clr_bits) | set_bits
                                 | edge_hit);
        end
    end

    // ------------------------------------------------------------------
    // Nesting stack and current interrupt.
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            sp_r <= 4'h0;
            cur_num_r <= 5'h0;
            cur_lvl_r <= 3'h0;
            for (int i = 0; i < irq_ctrl_pkg::STACK_DEPTH; i++) begin
                stk_num_r[i] <= 5'h0;
                stk_lvl_r[i] <= 3'h0;
            end
        end else if (ivr_rd && best_ok &&
                     sp_r < 4'(irq_ctrl_pkg::STACK_DEPTH)) begin
            // The running number and level are saved below the new one.
            stk_num_r[sp_r[2:0]] <= cur_num_r;
            stk_lvl_r[sp_r[2:0]] <= cur_lvl_r;
            sp_r <= sp_r + 4'h1;
            cur_num_r <= best_num;
            cur_lvl_r <= best_lvl;
        end else if (eoi_wr && serving) begin
            sp_r <= sp_r - 4'h1;
            cur_num_r <= stk_num_r[3'(sp_r - 4'h1)];
            cur_lvl_r <= stk_lvl_r[3'(sp_r - 4'h1)];
        end
    end

    // Fast line register; declared here, ahead of the output assignments.
    logic fiq_r;

    // Normal line; a vector read drops it for a cycle, then it re-evaluates.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            normal_request_n_r <= 1'b0;
        end else if (ivr_rd) begin
            normal_request_n_r <= 1'b0;
        end else begin
            normal_request_n_r <= normal_request_n_nxt;
        end
    end
    assign NORMAL_REQUEST_N_OUT = ~normal_request_n_r;
    assign FAST_REQUEST_N_OUT = ~fiq_r;

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            fiq_r <= 1'b0;
        end else begin
            fiq_r <= fiq;
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge; unmapped reads return zero.
    // ------------------------------------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            if (WB_ADR_IN == irq_ctrl_pkg::MODE_BASE + 10'(i * 4)) begin
                rmux = mode_r[i];
            end
            if (WB_ADR_IN == irq_ctrl_pkg::VECT_BASE + 10'(i * 4)) begin
                rmux = vect_r[i];
            end
        end
        case (WB_ADR_IN)
            irq_ctrl_pkg::NORMAL_VECTOR_OFS: begin
                rmux = best_ok ? vect_r[best_num] : vect_r[0];
            end
            irq_ctrl_pkg::FAST_VECTOR_OFS: rmux = vect_r[0];
            irq_ctrl_pkg::CURRENT_NUMBER_OFS: begin
                rmux = {27'h0, cur_num_r};
            end
            irq_ctrl_pkg::PENDING_OFS: rmux = pending;
            irq_ctrl_pkg::ENABLE_MASK_OFS: rmux = enable_r;
            irq_ctrl_pkg::CORE_LINE_OFS: begin
                rmux = {30'h0, normal_request_n_r, fiq_r};
            end
            irq_ctrl_pkg::FAST_FORCE_OFS: rmux = force_r;
            irq_ctrl_pkg::EXTERNAL_SEL_OFS: rmux = ext_sel_r;
            default: begin
            end
        endcase
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (rd) begin
                rdata_r <= rmux;
            end
        end
    end
    assign WB_ACK_OUT = ack_r;
    assign WB_DAT_OUT = rdata_r;
endmodule : vectored_irq_ctrl

// ---- tb/irq_core_model.sv ----
// Processor core model that counts entries on each request line.
`timescale 1ns/1ns
module irq_core_model (
    input logic clk_in,
    input logic rst_in,
    input logic normal_n_in,
    input logic fast_n_in,
    output int normal_cnt_out,
    output int fast_cnt_out
);
    // ------------------------------------------------------------------
    // Entry counting.
    // ------------------------------------------------------------------
    logic normal_d_r;
    logic fast_d_r;
    // Each falling line is one entry; software then reads the vector.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            normal_d_r <= 1'b1;
            fast_d_r <= 1'b1;
            normal_cnt_out <= 0;
            fast_cnt_out <= 0;
        end else begin
            normal_d_r <= normal_n_in;
            fast_d_r <= fast_n_in;
            if (normal_d_r && !normal_n_in) begin
                normal_cnt_out <= normal_cnt_out + 1;
            end
            if (fast_d_r && !fast_n_in) begin
                fast_cnt_out <= fast_cnt_out + 1;
            end
        end
    end
endmodule : irq_core_model

// ---- tb/irq_ctrl_asserts.sv ----
// Port level checker for the vectored interrupt controller.
`timescale 1ns/1ns
module irq_ctrl_asserts #(
    parameter int NUM_SRC = 32
) (
    input logic MCLK_IN,
    input logic SYS_RST_IN,
    input logic WB_CYC_IN,
    input logic WB_STB_IN,
    input logic WB_WE_IN,
    input logic [9:0] WB_ADR_IN,
    input logic [31:0] WB_DAT_OUT,
    input logic WB_ACK_OUT,
    input logic NORMAL_REQUEST_N_OUT,
    input logic FAST_REQUEST_N_OUT
);
    // ------------------------------------------------------------------
    // Helper logic and assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    logic take;
    logic rd;
    logic wr_seen_r;
    // A request is taken only while ack is low.
    assign take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    assign rd = take && !WB_WE_IN;
    // Every source starts disabled, so no line may fall before a write.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            wr_seen_r <= 1'b0;
        end else if (take && WB_WE_IN) begin
            wr_seen_r <= 1'b1;
        end
    end
    a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (take |=> WB_ACK_OUT)
        else $error("request not answered");
    a_ack_cause: assert property (WB_ACK_OUT |-> $past(take))
        else $error("ack without request");
    a_reset_idle: assert property ($fell(SYS_RST_IN) |->
        NORMAL_REQUEST_N_OUT && FAST_REQUEST_N_OUT)
        else $error("line active after reset");
    a_vector_drop: assert property (rd && WB_ADR_IN ==
        irq_ctrl_pkg::NORMAL_VECTOR_OFS |=> ##[0:1] NORMAL_REQUEST_N_OUT)
        else $error("vector read kept normal line");
    a_core_image: assert property (rd && WB_ADR_IN ==
        irq_ctrl_pkg::CORE_LINE_OFS |=> WB_DAT_OUT[1:0] ==
        {!$past(NORMAL_REQUEST_N_OUT), !$past(FAST_REQUEST_N_OUT)})
        else $error("core line image wrong");
    a_rdata_holds: assert property (!rd |=> $stable(WB_DAT_OUT))
        else $error("read data moved without read");
    a_quiet_start: assert property (!wr_seen_r |->
        NORMAL_REQUEST_N_OUT && FAST_REQUEST_N_OUT)
        else $error("line active with all sources disabled");
    c_vec_read: cover property (rd && WB_ADR_IN ==
        irq_ctrl_pkg::NORMAL_VECTOR_OFS);
    c_normal_low: cover property (!NORMAL_REQUEST_N_OUT);
    c_fast_low: cover property (!FAST_REQUEST_N_OUT);
endmodule : irq_ctrl_asserts

bind vectored_irq_ctrl irq_ctrl_asserts #(.NUM_SRC(NUM_SRC)) u_chk (
    .MCLK_IN(MCLK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .WB_CYC_IN(WB_CYC_IN),
    .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN),
    .WB_ADR_IN(WB_ADR_IN),
    .WB_DAT_OUT(WB_DAT_OUT),
    .WB_ACK_OUT(WB_ACK_OUT),
    .NORMAL_REQUEST_N_OUT(NORMAL_REQUEST_N_OUT),
    .FAST_REQUEST_N_OUT(FAST_REQUEST_N_OUT)
);

// ---- tb/vectored_irq_ctrl_tb.sv ----
// Self-checking testbench for the vectored interrupt controller.
`timescale 1ns/1ns
module vectored_irq_ctrl_tb;
    // ------------------------------------------------------------------
    // Signals, model and design.
    // ------------------------------------------------------------------
    typedef struct {
        logic w;
        logic [9:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] src = 32'h0000_0000;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'hF;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic irq_n;
    logic fiq_n;
    logic [31:0] q;
    int n_cnt;
    int f_cnt;
    int errors = 0;
    int n_tests = 0;
    int k;
    int t;
    row_type rows[6];
    vectored_irq_ctrl dut (.MCLK_IN(clk), .SYS_RST_IN(rst), .SRC_IN(src),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(sel), .WB_DAT_IN(wd), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .NORMAL_REQUEST_N_OUT(irq_n),
        .FAST_REQUEST_N_OUT(fiq_n));
    irq_core_model core (.clk_in(clk), .rst_in(rst), .normal_n_in(irq_n),
        .fast_n_in(fiq_n), .normal_cnt_out(n_cnt), .fast_cnt_out(f_cnt));
    // Free running 250 MHz clock.
    initial begin
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------------
    task finish_test;
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp, string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // Classic cycle, entered just after a rising edge; ack and read data
    // are taken at the rising edge where ack is sampled high, then released.
    task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            chk(32'h0000_0000, 32'h0000_0001, "bus timeout");
            finish_test;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task wait_lvl(input bit f, input logic v);
        int i;
        for (i = 0; i < 20 && (f ? fiq_n : irq_n) !== v; i++) @(negedge clk);
        chk(32'(i < 20), 32'h0000_0001, "line wait");
        if (i == 20) begin
            finish_test;
        end
        @(posedge clk);
    endtask : wait_lvl
    task settle;
        repeat (4) @(posedge clk);
    endtask : settle
    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        rows = '{'{1'b1, irq_ctrl_pkg::ENABLE_CMD_OFS, 32'h0000_00F0, 0},
            '{1'b0, irq_ctrl_pkg::ENABLE_MASK_OFS, 0, 32'h0000_00F0},
            '{1'b1, irq_ctrl_pkg::DISABLE_CMD_OFS, 32'h0000_0030, 0},
            '{1'b0, irq_ctrl_pkg::ENABLE_MASK_OFS, 0, 32'h0000_00C0},
            '{1'b0, irq_ctrl_pkg::CURRENT_NUMBER_OFS, 0, 0},
            '{1'b0, 10'h3FC, 0, 0}};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(q, rows[i].e, "table");
        end
        $display("table done");
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, irq_ctrl_pkg::ENABLE_MASK_OFS, 0);
        chk(q, 32'h0000_0000, "mask after reset");
        $display("reset done");
        for (k = 0; k < 13; k++) wb(1'b1, 10'h080 + 10'(4 * k), 32'h1000 + k);
        wb(1'b1, 10'h008, 32'h0000_0003);
        wb(1'b1, 10'h014, 32'h0000_0003);
        wb(1'b1, 10'h01C, 32'h0000_0026);
        wb(1'b1, 10'h024, 32'h0000_0007);
        wb(1'b1, irq_ctrl_pkg::ENABLE_CMD_OFS, 32'h0000_00A4);
        src <= 32'h0000_0224;
        wait_lvl(1'b0, 1'b0);
        wb(1'b0, irq_ctrl_pkg::NORMAL_VECTOR_OFS, 0);
        chk(q, 32'h0000_1002, "tie");
        wb(1'b0, irq_ctrl_pkg::CURRENT_NUMBER_OFS, 0);
        chk(q, 32'h0000_0002, "current");
        chk(32'(irq_n), 32'h0000_0001, "equal level");
        src <= 32'h0000_02A4;
        wait_lvl(1'b0, 1'b0);
        src <= 32'h0000_0224;
        wb(1'b0, irq_ctrl_pkg::NORMAL_VECTOR_OFS, 0);
        chk(q, 32'h0000_1007, "nested");
        wb(1'b0, irq_ctrl_pkg::PENDING_OFS, 0);
        chk(q, 32'h0000_0224, "pending");
        wb(1'b1, irq_ctrl_pkg::END_OF_SERVICE_OFS, 0);
        wb(1'b0, irq_ctrl_pkg::CURRENT_NUMBER_OFS, 0);
        chk(q, 32'h0000_0002, "restored");
        chk(32'(irq_n), 32'h0000_0001, "not outranked");
        // The handler of source 2 removes its level before leaving.
        src <= 32'h0000_0220;
        wb(1'b1, irq_ctrl_pkg::END_OF_SERVICE_OFS, 0);
        wait_lvl(1'b0, 1'b0);
        wb(1'b0, irq_ctrl_pkg::NORMAL_VECTOR_OFS, 0);
        chk(q, 32'h0000_1005, "next");
        src <= 32'h0000_0000;
        wb(1'b1, irq_ctrl_pkg::END_OF_SERVICE_OFS, 0);
        chk(32'(n_cnt), 32'h0000_0003, "entries");
        $display("priority done");
        wb(1'b1, 10'h028, 32'h0000_0020);
        wb(1'b1, irq_ctrl_pkg::SET_CMD_OFS, 32'h0000_0C00);
        wb(1'b0, irq_ctrl_pkg::PENDING_OFS, 0);
        chk(q, 32'h0000_0400, "set");
        wb(1'b1, irq_ctrl_pkg::CLEAR_CMD_OFS, 32'h0000_0C00);
        wb(1'b0, irq_ctrl_pkg::PENDING_OFS, 0);
        chk(q, 32'h0000_0000, "clear");
        $display("set clear done");
        wb(1'b1, irq_ctrl_pkg::MODE_BASE, 32'h0000_0020);
        wb(1'b1, irq_ctrl_pkg::ENABLE_CMD_OFS, 32'h0000_0001);
        wb(1'b1, irq_ctrl_pkg::SET_CMD_OFS, 32'h0000_0001);
        wait_lvl(1'b1, 1'b0);
        wb(1'b0, irq_ctrl_pkg::CORE_LINE_OFS, 0);
        chk(q, 32'h0000_0001, "core lines");
        wb(1'b0, irq_ctrl_pkg::FAST_VECTOR_OFS, 0);
        wait_lvl(1'b1, 1'b1);
        chk(32'(f_cnt), 32'h0000_0001, "fast entries");
        $display("fast done");
        wb(1'b1, irq_ctrl_pkg::EXTERNAL_SEL_OFS, 32'h0000_1000);
        for (t = 0; t < 4; t++) begin
            wb(1'b1, 10'h030, 32'(t) << 5);
            src[12] <= !t[1];
            settle;
            wb(1'b1, irq_ctrl_pkg::CLEAR_CMD_OFS, 32'h0000_1000);
            src[12] <= t[1];
            settle;
            wb(1'b0, irq_ctrl_pkg::PENDING_OFS, 0);
            chk(32'(q[12]), 32'h0000_0001, "active");
            src[12] <= !t[1];
            settle;
            wb(1'b0, irq_ctrl_pkg::PENDING_OFS, 0);
            chk(32'(q[12]), 32'(t & 1), "after");
        end
        $display("external done");
        // A fast-forced edge source keeps its latch over a normal vector read.
        wb(1'b1, irq_ctrl_pkg::FAST_FORCE_OFS, 32'h0000_0400);
        wb(1'b1, irq_ctrl_pkg::ENABLE_CMD_OFS, 32'h0000_0400);
        wb(1'b1, irq_ctrl_pkg::SET_CMD_OFS, 32'h0000_0400);
        wait_lvl(1'b1, 1'b0);
        wb(1'b0, irq_ctrl_pkg::NORMAL_VECTOR_OFS, 0);
        wb(1'b0, irq_ctrl_pkg::PENDING_OFS, 0);
        chk(q, 32'h0000_1400, "forced kept");
        $display("forced done");
        finish_test;
    end
endmodule : vectored_irq_ctrl_tb
